//--- hw/smc_pkg.sv
// Constants, types and helpers shared by the supply aware mode controller.
//------------------------------------------------------------------------
// Functional notes
//------------------------------------------------------------------------
package smc_pkg;

    localparam int          SMC_CH            = 4;
    localparam int          SMC_ADDR_W        = 8;

    // Register map, byte addresses.
    localparam logic [7:0]  SMC_ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  SMC_ADDR_STATUS   = 8'h04;

    // Control register fields.
    localparam int          SMC_ON_LSB        = 0;
    localparam int          SMC_ROUTE_LSB     = 4;
    localparam int          SMC_SRST_BIT      = 8;
    localparam int          SMC_ERR_LSB       = 9;
    localparam logic [3:0]  SMC_ON_RESET      = 4'h0;
    localparam logic [2:0]  SMC_ROUTE_LOCK    = 3'h7;
    localparam logic [2:0]  SMC_ROUTE_RESET   = 3'h7;
    localparam logic [2:0]  SMC_ERR_RESET     = 3'h0;

    // Status register fields.
    localparam int          SMC_ST_MODE_LSB   = 0;
    localparam int          SMC_ST_CH_LSB     = 8;
    localparam int          SMC_ST_UV_BIT     = 12;
    localparam int          SMC_ST_POR_BIT    = 13;
    localparam int          SMC_ST_TRANS_BIT  = 14;
    localparam int          SMC_ST_LDONE_BIT  = 15;

    localparam logic [1:0]  SMC_RESP_OKAY     = 2'h0;
    localparam logic [1:0]  SMC_RESP_SLVERR   = 2'h2;

    // Delay from limp home entry to register reset.
    localparam int          SMC_CLK_PERIOD_NS = 10;
    localparam int          SMC_LIMP_RST_NS   = 1000;
    localparam int          SMC_LIMP_RST_CYC  =
        (SMC_LIMP_RST_NS + SMC_CLK_PERIOD_NS - 1) / SMC_CLK_PERIOD_NS;
    localparam int          SMC_CNT_W         = 16;

    typedef enum logic [4:0]
    {
        SMC_STANDBY = 5'h01,
        SMC_IDLE    = 5'h02,
        SMC_READY   = 5'h04,
        SMC_OPER    = 5'h08,
        SMC_LIMP    = 5'h10
    } smc_mode_type;

    typedef struct packed
    {
        logic logic_por_ok;
        logic bat_uv;
        logic bat_op;
        logic bat_transient;
    } smc_supply_type;

    // A channel switch-on request from the bus bits or the direct inputs.
    function automatic logic smc_request(input logic [SMC_CH-1:0] on_bits,
                                         input logic [SMC_CH-1:0] direct);
        smc_request = (|on_bits) | (|direct);
    endfunction

endpackage

//--- hw/smc_top.sv
// Operating mode controller with AXI4-Lite register access.
`timescale 1ns/100ps
module smc_top
(
    input  wire logic                           MCLK,
    input  wire logic                           RST,
    input  wire smc_pkg::smc_supply_type        SUPPLY,
    input  wire logic                           LIMP_HOME_INPUT,
    input  wire logic [smc_pkg::SMC_CH-1:0]     DIRECT_CHANNEL_INPUT,
    output logic      [smc_pkg::SMC_CH-1:0]     CHANNEL_ENABLE,
    output logic                                RETRY_CLEAR,
    output logic      [4:0]                     MODE,
    input  wire logic [smc_pkg::SMC_ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic                           S_AXI_AWVALID,
    output logic                                S_AXI_AWREADY,
    input  wire logic [31:0]                    S_AXI_WDATA,
    input  wire logic [3:0]                     S_AXI_WSTRB,
    input  wire logic                           S_AXI_WVALID,
    output logic                                S_AXI_WREADY,
    output logic      [1:0]                     S_AXI_BRESP,
    output logic                                S_AXI_BVALID,
    input  wire logic                           S_AXI_BREADY,
    input  wire logic [smc_pkg::SMC_ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic                           S_AXI_ARVALID,
    output logic                                S_AXI_ARREADY,
    output logic      [31:0]                    S_AXI_RDATA,
    output logic      [1:0]                     S_AXI_RRESP,
    output logic                                S_AXI_RVALID,
    input  wire logic                           S_AXI_RREADY
);

    //--------------------------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------------------------
    localparam int SW = 5 + smc_pkg::SMC_CH;

    logic [SW-1:0]              sync1_reg;
    logic [SW-1:0]              sync2_reg;
    logic                       por_s;
    logic                       uvin_s;
    logic                       opin_s;
    logic                       trans_s;
    logic                       lhi_s;
    logic [smc_pkg::SMC_CH-1:0] din_s;

    always_ff @(posedge MCLK)
    begin
        sync1_reg <= {SUPPLY, LIMP_HOME_INPUT, DIRECT_CHANNEL_INPUT};
        sync2_reg <= sync1_reg;
    end

    assign {por_s, uvin_s, opin_s, trans_s, lhi_s, din_s} = sync2_reg;

    //--------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------
    smc_pkg::smc_mode_type      mode_reg;
    smc_pkg::smc_mode_type      mode_next;
    logic                       uv_reg;
    logic                       uv_next;
    logic                       por_int_reg;
    logic [smc_pkg::SMC_CH-1:0] on_reg;
    logic [2:0]                 route_reg;
    logic [2:0]                 err_reg;
    logic [smc_pkg::SMC_CNT_W-1:0] limp_cnt_reg;
    logic                       aw_have_reg;
    logic                       w_have_reg;
    logic [smc_pkg::SMC_ADDR_W-1:0] awaddr_reg;
    logic [31:0]                wdata_reg;
    logic [3:0]                 wstrb_reg;
    logic [smc_pkg::SMC_CH-1:0] ch_next;

    //--------------------------------------------------------------------
    // Supply supervision
    //--------------------------------------------------------------------
    // latch undervoltage until operating level
    assign uv_next = uvin_s ? 1'b1 : (opin_s ? 1'b0 : uv_reg);

    wire limp_done  = (limp_cnt_reg ==
                       smc_pkg::SMC_CNT_W'(smc_pkg::SMC_LIMP_RST_CYC));
    // registers held at default without logic supply
    wire reg_clear  = ~por_s | limp_done;

    //--------------------------------------------------------------------
    // Mode decision
    //--------------------------------------------------------------------
    // route 111 locks channels off outside limp home
    wire route_lock = (route_reg == smc_pkg::SMC_ROUTE_LOCK);
    wire request    = smc_pkg::smc_request(on_reg, din_s);
    wire limp_req   = lhi_s & ~trans_s;

    // mode from limp, inputs, route, bits
    assign mode_next = limp_req   ? smc_pkg::SMC_LIMP :
                       route_lock ? (request ? smc_pkg::SMC_READY
                                             : smc_pkg::SMC_STANDBY) :
                       (request ? smc_pkg::SMC_OPER : smc_pkg::SMC_IDLE);

    wire ch_allow = ~uv_next & ~trans_s;

    always_comb
    begin
        ch_next = '0;
        case (mode_next)
            smc_pkg::SMC_LIMP: ch_next = ch_allow ? din_s : '0;
            smc_pkg::SMC_OPER: ch_next = ch_allow ? (on_reg | din_s) : '0;
            // stand-by, idle and ready hold outputs off
            default:           ch_next = '0;
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            mode_reg       <= smc_pkg::SMC_STANDBY;
            uv_reg         <= 1'b1;
            por_int_reg    <= 1'b0;
            CHANNEL_ENABLE <= '0;
            RETRY_CLEAR    <= 1'b1;
            MODE           <= smc_pkg::SMC_STANDBY;
        end
        else
        begin
            mode_reg       <= mode_next;
            MODE           <= mode_next;
            uv_reg         <= uv_next;
            por_int_reg    <= por_s & opin_s & ~uvin_s;
            CHANNEL_ENABLE <= ch_next;
            // retry counters cleared without logic supply
            RETRY_CLEAR    <= ~por_s;
        end
    end

    // delay counter from limp home entry
    always_ff @(posedge MCLK)
    begin
        if (RST || mode_reg != smc_pkg::SMC_LIMP)
            limp_cnt_reg <= '0;
        else if (!limp_done)
            limp_cnt_reg <= limp_cnt_reg + 1'b1;
    end

    //--------------------------------------------------------------------
    // Bus access policy
    //--------------------------------------------------------------------
    wire in_limp    = (mode_reg == smc_pkg::SMC_LIMP);
    wire in_standby = (mode_reg == smc_pkg::SMC_STANDBY);
    // transient rejects commands except in stand-by, or with route 111 outside ready and limp home
    wire trans_rej  = trans_s & ~in_standby &
                      (~route_lock | in_limp | mode_reg == smc_pkg::SMC_READY);
    // no bus function without logic supply
    wire rd_reject  = ~por_s | trans_rej;
    wire wr_reject  = rd_reject | in_limp;

    wire wr_fire    = aw_have_reg & w_have_reg & ~S_AXI_BVALID;
    wire wr_ctrl    = (awaddr_reg == smc_pkg::SMC_ADDR_CTRL);
    wire wr_ok      = wr_fire & wr_ctrl & ~wr_reject;
    wire soft_rst   = wr_ok & wstrb_reg[1] & wdata_reg[smc_pkg::SMC_SRST_BIT];

    //--------------------------------------------------------------------
    // AXI4-Lite write channel
    //--------------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            awaddr_reg    <= '0;
            wdata_reg     <= '0;
            wstrb_reg     <= '0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= smc_pkg::SMC_RESP_OKAY;
        end
        else
        begin
            S_AXI_AWREADY <= ~aw_have_reg & ~(S_AXI_AWVALID & S_AXI_AWREADY);
            S_AXI_WREADY  <= ~w_have_reg & ~(S_AXI_WVALID & S_AXI_WREADY);
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_have_reg <= 1'b1;
                awaddr_reg  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_have_reg <= 1'b1;
                wdata_reg  <= S_AXI_WDATA;
                wstrb_reg  <= S_AXI_WSTRB;
            end
            if (wr_fire)
            begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_ok ? smc_pkg::SMC_RESP_OKAY
                                      : smc_pkg::SMC_RESP_SLVERR;
            end
            else if (S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
        end
    end

    //--------------------------------------------------------------------
    // Control register
    //--------------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            on_reg    <= smc_pkg::SMC_ON_RESET;
            route_reg <= smc_pkg::SMC_ROUTE_RESET;
            err_reg   <= smc_pkg::SMC_ERR_RESET;
        end
        // logic supply low holds registers in reset
        else if (reg_clear)
        begin
            on_reg    <= smc_pkg::SMC_ON_RESET;
            route_reg <= smc_pkg::SMC_ROUTE_RESET;
            err_reg   <= smc_pkg::SMC_ERR_RESET;
        end
        // soft reset spares error route field
        else if (soft_rst)
        begin
            on_reg    <= smc_pkg::SMC_ON_RESET;
            route_reg <= smc_pkg::SMC_ROUTE_RESET;
        end
        else if (wr_ok)
        begin
            if (wstrb_reg[0])
            begin
                on_reg    <= wdata_reg[smc_pkg::SMC_ON_LSB +: smc_pkg::SMC_CH];
                route_reg <= wdata_reg[smc_pkg::SMC_ROUTE_LSB +: 3];
            end
            if (wstrb_reg[1])
                err_reg <= wdata_reg[smc_pkg::SMC_ERR_LSB +: 3];
        end
    end

    //--------------------------------------------------------------------
    // AXI4-Lite read channel
    //--------------------------------------------------------------------
    logic [31:0] ctrl_word;
    logic [31:0] status_word;

    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[smc_pkg::SMC_ON_LSB +: smc_pkg::SMC_CH] = on_reg;
        ctrl_word[smc_pkg::SMC_ROUTE_LSB +: 3]            = route_reg;
        ctrl_word[smc_pkg::SMC_ERR_LSB +: 3]              = err_reg;
        status_word = '0;
        status_word[smc_pkg::SMC_ST_MODE_LSB +: 5]        = mode_reg;
        status_word[smc_pkg::SMC_ST_CH_LSB +: smc_pkg::SMC_CH] = CHANNEL_ENABLE;
        status_word[smc_pkg::SMC_ST_UV_BIT]               = uv_reg;
        status_word[smc_pkg::SMC_ST_POR_BIT]              = por_int_reg;
        status_word[smc_pkg::SMC_ST_TRANS_BIT]            = trans_s;
        status_word[smc_pkg::SMC_ST_LDONE_BIT]            = limp_done;
    end

    wire rd_fire   = S_AXI_ARVALID & S_AXI_ARREADY;
    wire rd_ctrl   = (S_AXI_ARADDR == smc_pkg::SMC_ADDR_CTRL);
    wire rd_status = (S_AXI_ARADDR == smc_pkg::SMC_ADDR_STATUS);
    wire rd_ok     = ~rd_reject & (rd_ctrl | rd_status);

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= '0;
            S_AXI_RRESP   <= smc_pkg::SMC_RESP_OKAY;
        end
        else
        begin
            S_AXI_ARREADY <= ~S_AXI_RVALID & ~rd_fire;
            if (rd_fire)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= ~rd_ok ? 32'h0000_0000 :
                                (rd_ctrl ? ctrl_word : status_word);
                S_AXI_RRESP  <= rd_ok ? smc_pkg::SMC_RESP_OKAY
                                      : smc_pkg::SMC_RESP_SLVERR;
            end
            else if (S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    por_clear_a: assert property (@(posedge MCLK) disable iff (RST)
        !por_s |=> (on_reg == smc_pkg::SMC_ON_RESET &&
                    route_reg == smc_pkg::SMC_ROUTE_RESET))
        else $error("registers not defaulted without logic supply");

    retry_clr_a: assert property (@(posedge MCLK) disable iff (RST)
        !por_s |=> RETRY_CLEAR)
        else $error("retry clear missing without logic supply");

    uv_off_a: assert property (@(posedge MCLK) disable iff (RST)
        uvin_s |=> (CHANNEL_ENABLE == '0) ##1 (CHANNEL_ENABLE == '0 || opin_s))
        else $error("channel on during battery undervoltage");

    trans_rej_a: assert property (@(posedge MCLK) disable iff (RST)
        (wr_fire && trans_s && !route_lock && !in_standby && !reg_clear)
        |=> (S_AXI_BVALID && S_AXI_BRESP == smc_pkg::SMC_RESP_SLVERR && $stable(on_reg)))
        else $error("write accepted during battery transient");

    trans_nolimp_a: assert property (@(posedge MCLK) disable iff (RST)
        trans_s |=> (mode_reg != smc_pkg::SMC_LIMP && CHANNEL_ENABLE == '0))
        else $error("limp home or channel on during battery transient");

    lock_off_a: assert property (@(posedge MCLK) disable iff (RST)
        (route_lock && !limp_req) |=> (CHANNEL_ENABLE == '0))
        else $error("channel on while route locked");

    limp_follow_a: assert property (@(posedge MCLK) disable iff (RST)
        (limp_req && !uv_next) |=> (CHANNEL_ENABLE == $past(din_s)))
        else $error("limp home output does not follow input");

    idle_oper_a: assert property (@(posedge MCLK) disable iff (RST)
        (!limp_req && !route_lock && request) |=> (MODE == smc_pkg::SMC_OPER))
        else $error("switch-on request did not reach operative mode");

    limp_wr_a: assert property (@(posedge MCLK) disable iff (RST)
        (wr_fire && in_limp && !reg_clear)
        |=> (S_AXI_BRESP == smc_pkg::SMC_RESP_SLVERR && $stable(on_reg)))
        else $error("write taken in limp home");

    soft_keep_a: assert property (@(posedge MCLK) disable iff (RST)
        (soft_rst && !reg_clear) |=> ($stable(err_reg) && route_reg == smc_pkg::SMC_ROUTE_RESET))
        else $error("soft reset disturbed error route field");

endmodule // smc_top

//--- tb/smc_supply_model.sv
// Supply comparator model that turns a battery level code into the supply flags.
`timescale 1ns/100ps
module smc_supply_model
(
    input  wire logic              bat_level,
    input  wire logic [1:0]        bat_code,
    input  wire logic              logic_ok,
    output smc_pkg::smc_supply_type supply
);
    //----------------------------------------------------------------
    // Comparators
    //----------------------------------------------------------------
    // Codes: 0 below transient level, 1 below undervoltage, 2 in hysteresis, 3 operating.
    // logic flag
    assign supply.logic_por_ok  = logic_ok;
    assign supply.bat_uv        = (bat_code < 2'h2);
    assign supply.bat_op        = (bat_code == 2'h3) & bat_level;
    assign supply.bat_transient = (bat_code == 2'h0);
endmodule // smc_supply_model

//--- tb/tb_top.sv
// Self-checking bench for the supply aware mode controller.
`timescale 1ns/100ps
module tb_top;
    localparam logic [7:0] A_CT = smc_pkg::SMC_ADDR_CTRL;
    localparam logic [7:0] A_ST = smc_pkg::SMC_ADDR_STATUS;
    localparam logic [1:0] OK_R = smc_pkg::SMC_RESP_OKAY;
    localparam logic [1:0] ER_R = smc_pkg::SMC_RESP_SLVERR;
    logic                    mclk = 1'b0;
    logic                    rst = 1'b1;
    logic [1:0]              bat_code = 2'h3;
    logic                    logic_ok = 1'b1;
    logic                    limp = 1'b0;
    logic [3:0]              din = 4'h0;
    smc_pkg::smc_supply_type supply;
    logic [3:0]              ce;
    logic                    retry_clr;
    logic [4:0]              mode;
    logic [7:0]              awaddr = 8'h00;
    logic                    awvalid = 1'b0;
    logic                    awready;
    logic [31:0]             wdata = 32'h0;
    logic [3:0]              wstrb = 4'h0;
    logic                    wvalid = 1'b0;
    logic                    wready;
    logic [1:0]              bresp;
    logic                    bvalid;
    logic                    bready = 1'b0;
    logic [7:0]              araddr = 8'h00;
    logic                    arvalid = 1'b0;
    logic                    arready;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic                    rvalid;
    logic                    rready = 1'b0;
    logic [1:0]              b_exp[$];
    logic [33:0]             r_exp[$];
    logic [33:0]             r_note;
    logic [31:0]             seed = 32'h15bd53a2;
    logic [3:0]              on;
    logic [3:0]              d;
    int                      n_errors = 0;
    int                      comparisons = 0;

    always #5 mclk = ~mclk;

    smc_supply_model i_supply (.bat_level(1'b1), .bat_code(bat_code), .logic_ok(logic_ok),
                               .supply(supply));

    smc_top i_dut (.MCLK(mclk), .RST(rst), .SUPPLY(supply), .LIMP_HOME_INPUT(limp),
        .DIRECT_CHANNEL_INPUT(din), .CHANNEL_ENABLE(ce), .RETRY_CLEAR(retry_clr), .MODE(mode),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    //----------------------------------------------------------------
    // Helpers
    //----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Nonzero random channel pattern.
    function automatic logic [3:0] rnd4();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[3:0] | 4'h1;
    endfunction

    task automatic set_in(input logic [1:0] b, input logic ok, input logic l, input logic [3:0] v);
        @(posedge mclk);
        bat_code <= b;
        logic_ok <= ok;
        limp <= l;
        din <= v;
    endtask

    // Lets the synchroniser settle, then samples mode and channels.
    task automatic expect_out(input logic [4:0] m, input logic [3:0] c);
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        check({27'h0, mode}, {27'h0, m});
        check({28'h0, ce}, {28'h0, c});
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                             input logic [1:0] r);
        logic aw_hs;
        logic w_hs;
        logic b_hs;
        b_exp.push_back(r);
        @(posedge mclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_hs = 1'b0;
        for (int i = 0; i < 50 && !b_hs; i++)
        begin
            @(negedge mclk);
            aw_hs = awvalid & (awready === 1'b1);
            w_hs = wvalid & (wready === 1'b1);
            b_hs = bvalid === 1'b1;
            @(posedge mclk);
            if (aw_hs)
                awvalid <= 1'b0;
            if (w_hs)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!b_hs)
        begin
            n_errors++;
            results();
        end
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [33:0] e);
        logic ar_hs;
        logic r_hs;
        r_exp.push_back(e);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_hs = 1'b0;
        for (int i = 0; i < 50 && !r_hs; i++)
        begin
            @(negedge mclk);
            ar_hs = arvalid & (arready === 1'b1);
            r_hs = rvalid === 1'b1;
            @(posedge mclk);
            if (ar_hs)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!r_hs)
        begin
            n_errors++;
            results();
        end
    endtask

    //----------------------------------------------------------------
    // Response monitor
    //----------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (bvalid === 1'b1 && bready)
            check({30'h0, bresp}, {30'h0, b_exp.pop_front()});
        if (rvalid === 1'b1 && rready)
        begin
            r_note = r_exp.pop_front();
            check({30'h0, rresp}, {30'h0, r_note[33:32]});
            check(rdata, r_note[31:0]);
        end
    end

    //----------------------------------------------------------------
    // Main sequence
    //----------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        expect_out(5'h01, 4'h0);
        axi_read(A_CT, {OK_R, 32'h70});
        on = rnd4();
        axi_write(A_CT, {24'h0, 4'h7, on}, 4'hf, OK_R);
        expect_out(5'h04, 4'h0);
        axi_write(A_CT, {28'h0, on}, 4'hf, OK_R);
        expect_out(5'h08, on);
        axi_read(A_ST, {OK_R, 32'h2008 | (32'(on) << 8)});
        set_in(2'h1, 1'b1, 1'b0, 4'h0);
        expect_out(5'h08, 4'h0);
        axi_read(A_ST, {OK_R, 32'h1008});
        set_in(2'h2, 1'b1, 1'b0, 4'h0);
        expect_out(5'h08, 4'h0);
        set_in(2'h3, 1'b1, 1'b0, 4'h0);
        expect_out(5'h08, on);
        d = rnd4();
        set_in(2'h0, 1'b1, 1'b1, d);
        expect_out(5'h08, 4'h0);
        axi_write(A_CT, 32'h0, 4'hf, ER_R);
        axi_read(A_CT, {ER_R, 32'h0});
        set_in(2'h3, 1'b1, 1'b0, 4'h0);
        axi_write(A_CT, 32'h0, 4'hf, OK_R);
        expect_out(5'h02, 4'h0);
        set_in(2'h3, 1'b1, 1'b0, d);
        expect_out(5'h08, d);
        set_in(2'h3, 1'b1, 1'b0, 4'h0);
        axi_write(A_CT, 32'h70, 4'hf, OK_R);
        expect_out(5'h01, 4'h0);
        set_in(2'h0, 1'b1, 1'b0, 4'h0);
        axi_write(A_CT, 32'h70, 4'hf, OK_R);
        set_in(2'h3, 1'b1, 1'b0, 4'h0);
        axi_write(A_CT, 32'h01, 4'hf, OK_R);
        expect_out(5'h08, 4'h1);
        d = rnd4();
        set_in(2'h3, 1'b1, 1'b1, d);
        expect_out(5'h10, d);
        axi_write(A_CT, 32'h0, 4'hf, ER_R);
        repeat (smc_pkg::SMC_LIMP_RST_CYC) @(posedge mclk);
        axi_read(A_CT, {OK_R, 32'h70});
        set_in(2'h3, 1'b0, 1'b1, d);
        expect_out(5'h10, d);
        check({31'h0, retry_clr}, 32'h1);
        axi_write(A_CT, 32'h01, 4'hf, ER_R);
        axi_read(A_CT, {ER_R, 32'h0});
        set_in(2'h3, 1'b1, 1'b0, 4'h0);
        expect_out(5'h01, 4'h0);
        check({31'h0, retry_clr}, 32'h0);
        axi_read(A_CT, {OK_R, 32'h70});
        axi_write(A_CT, 32'h0a05, 4'hf, OK_R);
        axi_write(A_CT, 32'h0b00, 4'h2, OK_R);
        axi_read(A_CT, {OK_R, 32'h0a70});
        axi_write(8'h08, 32'h0, 4'hf, ER_R);
        axi_write(A_ST, 32'h0, 4'hf, ER_R);
        axi_read(8'h0c, {ER_R, 32'h0});
        repeat (3) @(posedge mclk);
        results();
    end
endmodule // tb_top
